// File: lxr_pkg.sv
// Package with register map constants for the LED expander registers
package lxr_pkg;
  localparam int LXR_AW = 8;
  localparam int LXR_DW = 8;
  localparam int LXR_NPORT = 16;
  localparam logic [7:0] LXR_INPUT_LOW = 8'h00;
  localparam logic [7:0] LXR_INPUT_HIGH = 8'h01;
  localparam logic [7:0] LXR_PHASE0_LOW = 8'h02;
  localparam logic [7:0] LXR_PHASE0_HIGH = 8'h03;
  localparam logic [7:0] LXR_POLARITY_LOW = 8'h04;
  localparam logic [7:0] LXR_POLARITY_HIGH = 8'h05;
  localparam logic [7:0] LXR_DIR_LOW = 8'h06;
  localparam logic [7:0] LXR_DIR_HIGH = 8'h07;
  localparam logic [7:0] LXR_PHASE1_LOW = 8'h0B;
  localparam logic [7:0] LXR_PHASE1_HIGH = 8'h0C;
  localparam logic [7:0] LXR_MASTER = 8'h0E;
  localparam logic [7:0] LXR_CONFIG = 8'h0F;
  localparam logic [7:0] LXR_INTENS_BASE = 8'h10;
  localparam logic [7:0] LXR_INTENS_LAST = 8'h17;
  localparam logic [7:0] LXR_INTENS_9_8 = 8'h14;
  localparam logic [7:0] LXR_INTENS_11_10 = 8'h15;
  localparam logic [7:0] LXR_INTENS_13_12 = 8'h16;
  localparam logic [7:0] LXR_INTENS_15_14 = 8'h17;
  // Reset values: blink and PWM off, ports as inputs, outputs released
  localparam logic [7:0] LXR_RST_ZERO = 8'h00;
  localparam logic [7:0] LXR_RST_ONES = 8'hFF;
  localparam logic [7:0] LXR_RST_CONFIG = 8'h00;
  localparam logic [7:0] LXR_RST_MASTER = 8'h00;
  localparam int LXR_CFG_BLINK_BIT = 0;
  localparam int LXR_CFG_PHASE_BIT = 1;
  localparam logic [3:0] LXR_FULL_DUTY = 4'hF;
  localparam int LXR_PWM_STEPS = 16;
endpackage

// File: lxr_pwm.sv
// Per-port duty generator for 4-bit intensity fields
`timescale 1ns/1ns
`default_nettype none
module lxr_pwm #(
  parameter int NPORT = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] slot,
  input wire logic [NPORT*4-1:0] level,
  output logic [NPORT-1:0] on
);
  import lxr_pkg::*;
  logic [NPORT-1:0] on_d;
  logic [NPORT-1:0] on_q;
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      // Value n lights slots 0..n, so n+1 of 16; 1111 stays static
      always_comb begin
        on_d[g] = (level[g*4 +: 4] == LXR_FULL_DUTY) || (slot <= level[g*4 +: 4]);
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (rst) begin
      on_q <= '0;
    end else begin
      on_q <= on_d;
    end
  end
  assign on = on_q;
endmodule
`default_nettype wire

// File: lxr_regs.sv
// Register bank of the 16-port LED expander with blink and intensity control
// What this block does
// - Ports 9/8 intensity at 0x14, ports 11/10 at 0x15, high/low nibbles.
// - Ports 13/12 intensity at 0x16, ports 15/14 at 0x17, high/low nibbles.
// - Intensity registers read back exactly what was last written.
// - Polarity addresses ignore writes and read zero.
// - Blink phase 0 sits at legacy output addresses 0x02, 0x03.
// - Blink phase 1 registers sit at 0x0B and 0x0C.
// - Master and extra output intensity share register 0x0E.
// - Blink and PWM are disabled after reset until host enables them.
// - Ports 0-7 share one phase register, ports 8-15 another.
// - Extra output is driven from its own nibble of register 0x0E, apart from ports.
// - Intensity 0000 gives one sixteenth duty, each step adds one sixteenth.
// - Intensity 1111 gives full static level without modulation.
`timescale 1ns/1ns
`default_nettype none
module lxr_regs #(
  parameter int NPORT = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [lxr_pkg::LXR_AW-1:0] reg_addr,
  input wire logic [lxr_pkg::LXR_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lxr_pkg::LXR_DW-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [NPORT-1:0] port_pins_in,
  output logic [NPORT-1:0] port_pins_out,
  output logic [NPORT-1:0] port_pins_oe_n,
  output logic extra_output
);
  import lxr_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  logic [15:0] phase0_q, phase0_d;
  logic [15:0] phase1_q, phase1_d;
  logic [15:0] dir_q, dir_d;
  logic [7:0] master_q, master_d;
  logic [7:0] config_q, config_d;
  logic [7:0] intens_q [0:7];
  logic [7:0] intens_d [0:7];
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [15:0] pins_q, pins_d;
  logic [15:0] oe_n_q, oe_n_d;
  logic extra_q, extra_d;
  logic [3:0] slot_q, slot_d;
  logic [NPORT-1:0] pwm_on;
  logic [NPORT*4-1:0] levels;
  logic [7:0] idx;

  // Register writes
  always_comb begin
    phase0_d = phase0_q;
    phase1_d = phase1_q;
    dir_d = dir_q;
    master_d = master_q;
    config_d = config_q;
    idx = reg_addr - LXR_INTENS_BASE;
    for (int i = 0; i < 8; i++) begin
      intens_d[i] = intens_q[i];
    end
    if (reg_wr) begin
      if (hit(reg_addr, LXR_PHASE0_LOW)) phase0_d[7:0] = reg_wdata;
      if (hit(reg_addr, LXR_PHASE0_HIGH)) phase0_d[15:8] = reg_wdata;
      if (hit(reg_addr, LXR_PHASE1_LOW)) phase1_d[7:0] = reg_wdata;
      if (hit(reg_addr, LXR_PHASE1_HIGH)) phase1_d[15:8] = reg_wdata;
      if (hit(reg_addr, LXR_DIR_LOW)) dir_d[7:0] = reg_wdata;
      if (hit(reg_addr, LXR_DIR_HIGH)) dir_d[15:8] = reg_wdata;
      if (hit(reg_addr, LXR_MASTER)) master_d = reg_wdata;
      if (hit(reg_addr, LXR_CONFIG)) config_d = reg_wdata;
      // Polarity addresses fall through with no storage
      if (reg_addr >= LXR_INTENS_BASE && reg_addr <= LXR_INTENS_LAST) begin
        intens_d[idx[2:0]] = reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase0_q <= {LXR_RST_ONES, LXR_RST_ONES};
      phase1_q <= {LXR_RST_ONES, LXR_RST_ONES};
      dir_q <= {LXR_RST_ONES, LXR_RST_ONES};
      master_q <= LXR_RST_MASTER;
      config_q <= LXR_RST_CONFIG;
      for (int i = 0; i < 8; i++) begin
        intens_q[i] <= LXR_RST_ONES;
      end
    end else begin
      phase0_q <= phase0_d;
      phase1_q <= phase1_d;
      dir_q <= dir_d;
      master_q <= master_d;
      config_q <= config_d;
      for (int i = 0; i < 8; i++) begin
        intens_q[i] <= intens_d[i];
      end
    end
  end

  // Register reads, one cycle after the strobe
  always_comb begin
    rvalid_d = reg_rd;
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = 8'h00;
      if (hit(reg_addr, LXR_INPUT_LOW)) rdata_d = port_pins_in[7:0];
      if (hit(reg_addr, LXR_INPUT_HIGH)) rdata_d = port_pins_in[15:8];
      if (hit(reg_addr, LXR_PHASE0_LOW)) rdata_d = phase0_q[7:0];
      if (hit(reg_addr, LXR_PHASE0_HIGH)) rdata_d = phase0_q[15:8];
      if (hit(reg_addr, LXR_PHASE1_LOW)) rdata_d = phase1_q[7:0];
      if (hit(reg_addr, LXR_PHASE1_HIGH)) rdata_d = phase1_q[15:8];
      if (hit(reg_addr, LXR_DIR_LOW)) rdata_d = dir_q[7:0];
      if (hit(reg_addr, LXR_DIR_HIGH)) rdata_d = dir_q[15:8];
      if (hit(reg_addr, LXR_MASTER)) rdata_d = master_q;
      if (hit(reg_addr, LXR_CONFIG)) rdata_d = config_q;
      if (reg_addr >= LXR_INTENS_BASE && reg_addr <= LXR_INTENS_LAST) begin
        rdata_d = intens_q[idx[2:0]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Duty slot counter; a PWM period is sixteen slots
  always_comb begin
    slot_d = slot_q + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      slot_q <= 4'h0;
    end else begin
      slot_q <= slot_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_lvl
      // Even port in low nibble, odd port in high nibble
      assign levels[g*4 +: 4] = g[0] ? intens_q[g/2][7:4] : intens_q[g/2][3:0];
    end
  endgenerate

  lxr_pwm #(.NPORT(NPORT)) u_pwm (
    .clk(clk),
    .rst(rst),
    .slot(slot_q),
    .level(levels),
    .on(pwm_on)
  );

  // Output drive. Open drain: low enable means pin is pulled low
  always_comb begin
    logic [15:0] sel;
    logic blink_en;
    logic pwm_en;
    sel = '0;
    blink_en = config_q[LXR_CFG_BLINK_BIT];
    pwm_en = (master_q[7:4] != 4'h0);
    // Blink off means phase 0 alone decides, PWM off means static level
    sel = (blink_en && config_q[LXR_CFG_PHASE_BIT]) ? phase1_q : phase0_q;
    for (int i = 0; i < 16; i++) begin
      pins_d[i] = 1'b0;
      oe_n_d[i] = !(!dir_q[i] && (!sel[i]) && (pwm_en ? pwm_on[i] : 1'b1));
    end
    // Extra output follows master_q[3:0] duty, only while master_q[7:4] is nonzero
    extra_d = pwm_en && (slot_q <= master_q[3:0]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pins_q <= '0;
      oe_n_q <= {LXR_RST_ONES, LXR_RST_ONES};
      extra_q <= 1'b0;
    end else begin
      pins_q <= pins_d;
      oe_n_q <= oe_n_d;
      extra_q <= extra_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign port_pins_out = pins_q;
  assign port_pins_oe_n = oe_n_q;
  assign extra_output = extra_q;

  property p_polarity_zero;
    @(posedge clk) disable iff (rst)
      reg_rd && (reg_addr == LXR_POLARITY_LOW || reg_addr == LXR_POLARITY_HIGH)
      |=> reg_rvalid && reg_rdata == 8'h00;
  endproperty
  a_polarity_zero: assert property (p_polarity_zero) else $error("polarity nonzero");

  sequence s_wr_intens;
    reg_wr && !reg_rd && reg_addr == LXR_INTENS_9_8;
  endsequence
  property p_readback;
    logic [7:0] v;
    @(posedge clk) disable iff (rst)
      (s_wr_intens, v = reg_wdata) ##1 (reg_rd && !reg_wr && reg_addr == LXR_INTENS_9_8)
      |=> reg_rdata == v;
  endproperty
  a_readback: assert property (p_readback) else $error("intensity readback wrong");

  property p_read_latency;
    @(posedge clk) disable iff (rst) reg_rd |=> reg_rvalid;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read not answered");

  property p_input_read;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == LXR_INPUT_HIGH |=> reg_rdata == $past(port_pins_in[15:8]);
  endproperty
  a_input_read: assert property (p_input_read) else $error("input read wrong");

  property p_reset_disabled;
    @(posedge clk) $fell(rst) |-> config_q == 8'h00 && master_q == 8'h00;
  endproperty
  a_reset_disabled: assert property (p_reset_disabled) else $error("features on after reset");

  property p_full_static;
    @(posedge clk) disable iff (rst)
      levels[35:32] == LXR_FULL_DUTY |=> pwm_on[8];
  endproperty
  a_full_static: assert property (p_full_static) else $error("full duty modulated");

  property p_min_duty;
    @(posedge clk) disable iff (rst)
      levels[39:36] == 4'h0 && slot_q == 4'h1 |=> !pwm_on[9];
  endproperty
  a_min_duty: assert property (p_min_duty) else $error("duty above one sixteenth");

  property p_phase1_store;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == LXR_PHASE1_HIGH |=> phase1_q[15:8] == $past(reg_wdata);
  endproperty
  a_phase1_store: assert property (p_phase1_store) else $error("phase 1 not stored");

  property p_extra_full;
    @(posedge clk) disable iff (rst)
      master_q[7:4] != 4'h0 && master_q[3:0] == LXR_FULL_DUTY |=> extra_output;
  endproperty
  a_extra_full: assert property (p_extra_full) else $error("extra output not static");

  property p_phase0_store;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == LXR_PHASE0_LOW |=> phase0_q[7:0] == $past(reg_wdata);
  endproperty
  a_phase0_store: assert property (p_phase0_store) else $error("phase 0 not stored");

  property p_master_store;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == LXR_MASTER |=> master_q == $past(reg_wdata);
  endproperty
  a_master_store: assert property (p_master_store) else $error("master not stored");

  property p_nibble_low;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == LXR_INTENS_9_8 |=> levels[39:36] == $past(reg_wdata[7:4])
      && levels[35:32] == $past(reg_wdata[3:0]);
  endproperty
  a_nibble_low: assert property (p_nibble_low) else $error("ports 9 8 nibbles misplaced");

  property p_nibble_high;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == LXR_INTENS_15_14 |=> levels[63:60] == $past(reg_wdata[7:4])
      && levels[59:56] == $past(reg_wdata[3:0]);
  endproperty
  a_nibble_high: assert property (p_nibble_high) else $error("ports 15 14 nibbles misplaced");

  property p_static_phase0;
    @(posedge clk) disable iff (rst)
      !config_q[LXR_CFG_BLINK_BIT] && master_q[7:4] == 4'h0
      |=> port_pins_oe_n == $past(dir_q | phase0_q);
  endproperty
  a_static_phase0: assert property (p_static_phase0) else $error("static drive wrong");

  property p_blink_phase1;
    @(posedge clk) disable iff (rst)
      config_q[LXR_CFG_BLINK_BIT] && config_q[LXR_CFG_PHASE_BIT] && master_q[7:4] == 4'h0
      |=> port_pins_oe_n == $past(dir_q | phase1_q);
  endproperty
  a_blink_phase1: assert property (p_blink_phase1) else $error("phase 1 drive wrong");

  property p_extra_off;
    @(posedge clk) disable iff (rst)
      master_q[7:4] == 4'h0 |=> !extra_output;
  endproperty
  a_extra_off: assert property (p_extra_off) else $error("extra output on with pwm off");

  property p_rvalid_pulse;
    @(posedge clk) disable iff (rst)
      !reg_rd |=> !reg_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");

  // Duty audit on port 8; pwm_on lags levels by a cycle, so audit a delayed copy
  logic [3:0] aud_lvl_q, aud_lvl_d;
  logic [3:0] aud_ref_q, aud_ref_d;
  logic [4:0] aud_cnt_q, aud_cnt_d;
  logic aud_same_q, aud_same_d;
  logic aud_arm_q, aud_arm_d;

  always_comb begin
    aud_lvl_d = levels[35:32];
    aud_ref_d = aud_ref_q;
    aud_cnt_d = aud_cnt_q + {4'h0, pwm_on[8]};
    aud_same_d = aud_same_q && (aud_lvl_q == aud_ref_q);
    aud_arm_d = aud_arm_q;
    // Slot 1 here shows slot 0 at the duty output, so a period starts
    if (slot_q == 4'h1) begin
      aud_ref_d = aud_lvl_q;
      aud_cnt_d = {4'h0, pwm_on[8]};
      aud_same_d = 1'b1;
      aud_arm_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aud_lvl_q <= LXR_FULL_DUTY;
      aud_ref_q <= LXR_FULL_DUTY;
      aud_cnt_q <= 5'h00;
      aud_same_q <= 1'b0;
      aud_arm_q <= 1'b0;
    end else begin
      aud_lvl_q <= aud_lvl_d;
      aud_ref_q <= aud_ref_d;
      aud_cnt_q <= aud_cnt_d;
      aud_same_q <= aud_same_d;
      aud_arm_q <= aud_arm_d;
    end
  end

  sequence s_period_end;
    slot_q == 4'h1 && aud_arm_q && aud_same_q;
  endsequence
  property p_duty_period;
    @(posedge clk) disable iff (rst)
      s_period_end |-> aud_cnt_q == {1'b0, aud_ref_q} + 5'h01;
  endproperty
  a_duty_period: assert property (p_duty_period) else $error("duty count wrong");
endmodule
`default_nettype wire

// File: lxr_host.sv
// Host model issuing register writes and reads to the bank
`timescale 1ns/1ns
`default_nettype none
module lxr_host (
  input wire logic clk,
  output logic [lxr_pkg::LXR_AW-1:0] reg_addr,
  output logic [lxr_pkg::LXR_DW-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [lxr_pkg::LXR_DW-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  import lxr_pkg::*;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Called just after an edge; strobes may follow back to back
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    reg_addr = a;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
  // Released lines carry junk, never the last value
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// File: led_expander_register_map_tb_top.sv
// Self-checking testbench of the LED expander register bank
`timescale 1ns/1ns
`default_nettype none
module led_expander_register_map_tb_top;
  import lxr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [15:0] pins_in = 16'h0000;
  logic [15:0] pins_out;
  logic [15:0] oe_n;
  logic extra_output;
  int errors = 0;
  int num_checks = 0;
  localparam logic [7:0] IA [4] = '{8'h14, 8'h15, 8'h16, 8'h17};
  localparam logic [7:0] ID [4] = '{8'hA5, 8'h3C, 8'h96, 8'h0F};
  localparam logic [7:0] PA [5] = '{8'h02, 8'h03, 8'h0B, 8'h0C, 8'h0E};
  localparam logic [7:0] PD [5] = '{8'h81, 8'h42, 8'h24, 8'h18, 8'h5A};
  always #4 clk = ~clk;
  lxr_regs #(.NPORT(16)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .port_pins_in(pins_in), .port_pins_out(pins_out),
    .port_pins_oe_n(oe_n), .extra_output(extra_output));
  lxr_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    i_host.rd_reg(a, d, v);
    check({n, " valid"}, {15'h0000, v}, 16'h0001);
    check(n, {8'h00, d}, {8'h00, exp});
  endtask
  // Counts cycles with the pin pulled low over two PWM periods
  task automatic low_cycles(input int idx, input int exp);
    int n;
    n = 0;
    repeat (32) begin
      @(posedge clk);
      #1;
      if (oe_n[idx] === 1'b0) n++;
    end
    check($sformatf("low cycles port %0d", idx), n[15:0], exp[15:0]);
  endtask
  // Counts cycles with the extra output high over two PWM periods
  task automatic extra_cycles(input int exp);
    int n;
    n = 0;
    repeat (32) begin
      @(posedge clk);
      #1;
      if (extra_output === 1'b1) n++;
    end
    check("extra output high cycles", n[15:0], exp[15:0]);
  endtask
  // Static drive with PWM off under one configuration value
  task automatic blink_chk(input logic [7:0] cfg, input logic [15:0] exp);
    i_host.wr_reg(LXR_CONFIG, cfg);
    i_host.idle();
    @(posedge clk);
    #1;
    check($sformatf("oe_n with config %h", cfg), oe_n, exp);
  endtask
  task automatic t_reset();
    check("oe_n after reset", oe_n, 16'hFFFF);
    check("extra after reset", {15'h0000, extra_output}, 16'h0000);
    rd_chk("config", LXR_CONFIG, 8'h00);
    rd_chk("master", LXR_MASTER, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_intensity();
    foreach (IA[i]) i_host.wr_reg(IA[i], ID[i]);
    foreach (IA[i]) rd_chk("intensity", IA[i], ID[i]);
    i_host.wr_reg(LXR_INTENS_9_8, 8'h0F);
    rd_chk("intensity 9 8 at once", LXR_INTENS_9_8, 8'h0F);
    i_host.idle();
    $display("test intensity done");
  endtask
  task automatic t_fixed();
    pins_in = 16'hA55A;
    i_host.wr_reg(LXR_POLARITY_LOW, 8'hFF);
    i_host.wr_reg(LXR_POLARITY_HIGH, 8'hFF);
    i_host.wr_reg(8'h08, 8'h55);
    rd_chk("polarity low", LXR_POLARITY_LOW, 8'h00);
    rd_chk("polarity high", LXR_POLARITY_HIGH, 8'h00);
    rd_chk("unmapped", 8'h08, 8'h00);
    rd_chk("inputs low", LXR_INPUT_LOW, 8'h5A);
    rd_chk("inputs high", LXR_INPUT_HIGH, 8'hA5);
    i_host.idle();
    $display("test fixed places done");
  endtask
  task automatic t_phases();
    foreach (PA[i]) i_host.wr_reg(PA[i], PD[i]);
    i_host.wr_reg(LXR_DIR_LOW, 8'h33);
    foreach (PA[i]) rd_chk("phase or master", PA[i], PD[i]);
    rd_chk("direction low", LXR_DIR_LOW, 8'h33);
    i_host.idle();
    $display("test phase registers done");
  endtask
  task automatic t_output();
    i_host.wr_reg(LXR_DIR_LOW, 8'h00);
    i_host.wr_reg(LXR_DIR_HIGH, 8'h00);
    i_host.wr_reg(LXR_PHASE0_LOW, 8'h00);
    i_host.wr_reg(LXR_PHASE0_HIGH, 8'hFC);
    i_host.wr_reg(LXR_INTENS_9_8, 8'hF0);
    i_host.wr_reg(LXR_CONFIG, 8'h00);
    i_host.wr_reg(LXR_MASTER, 8'h00);
    i_host.idle();
    repeat (20) @(posedge clk);
    #1;
    check("oe_n with pwm off", oe_n, 16'hFC00);
    extra_cycles(0);
    blink_chk(8'h03, 16'h1824);
    blink_chk(8'h01, 16'hFC00);
    blink_chk(8'h02, 16'hFC00);
    i_host.wr_reg(LXR_MASTER, 8'hF0);
    i_host.idle();
    repeat (4) @(posedge clk);
    #1;
    low_cycles(0, 32);
    low_cycles(8, 2);
    low_cycles(9, 32);
    low_cycles(10, 0);
    check("pin out value", pins_out, 16'h0000);
    extra_cycles(2);
    i_host.wr_reg(LXR_MASTER, 8'hFF);
    i_host.idle();
    extra_cycles(32);
    $display("test output drive done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_intensity();
    t_fixed();
    t_phases();
    t_output();
    complete_run();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
